// ==== core/pafs_defs.svh ====
`ifndef PAFS_DEFS_SVH
`define PAFS_DEFS_SVH

// register byte offsets
`define PAFS_OFF_DATA      12'h000
`define PAFS_OFF_DIR       12'h004
`define PAFS_OFF_MODE      12'h008
`define PAFS_OFF_FSEL      12'h00C
`define PAFS_OFF_FSELX     12'h010
`define PAFS_OFF_RISE      12'h014
`define PAFS_OFF_FALL      12'h018
`define PAFS_OFF_PIN       12'h01C
`define PAFS_OFF_EVENT     12'h020

// pin field positions inside the 32-bit words
`define PAFS_P2_LSB        0
`define PAFS_P3_LSB        2
`define PAFS_P4_LSB        4
`define PAFS_P5_LSB        10
`define PAFS_P7_LSB        12
`define PAFS_AL_LSB        20
`define PAFS_NPINS         33

// reset values: every pin a port input, data low
`define PAFS_RST_DATA      33'h0_0000_0000
`define PAFS_RST_DIR       33'h1_FFFF_FFFF
`define PAFS_RST_MODE      33'h0_0000_0000
`define PAFS_RST_FSEL      33'h0_0000_0000

`endif

// ==== core/pafs_mux.sv ====
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pafs_defs.svh"

// Operation
// (RULE1) board holds debug reset low to use shared port-2 pins as port functions
// (RULE2) debug reset high overrides port-2 settings, pins become debug data in/out
// (RULE3) two-wire data and clock pins drive only low, never high
// (RULE4) port-4 data-out pin: function 0 clocked serial out, 1 uart transmit
// (RULE5) port-4 data-in pin: function 0 clocked serial in, 1 uart receive
// (RULE6) port-4 clock pin: function 0 serial clock, 1 uart baud clock in
// (RULE7) first port-5 pin: irq, timer out, or event/capture/timer irq together
// (RULE8) second port-5 pin: irq, timer out, or timer irq input
// (RULE9) port-5 irq edge comes from separate rising and falling select registers
// (RULE10) port-7 pins feed analog inputs when mode set, no direction bit
// (RULE11) port-8 pins always carry analog outputs, no settings needed
// (RULE12) low address pins output address bits 0..12 when mode set
// (RULE13) alternate function ignores data latch and direction; function sets direction
// (RULE14) mode bit 0 makes pin a general port bit under data and direction
module pafs_mux (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rstn_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // pads: bit order p2[1:0] p3[1:0] p4[5:0] p5[1:0] p7[7:0] al[12:0]
  input  wire logic [32:0]           pad_in_i,
  output logic      [32:0]           pad_out_o,
  output logic      [32:0]           pad_oe_o,
  input  wire logic                  debug_reset_i,
  // debug serial
  input  wire logic                  dbg_data_out_i,
  output logic                       dbg_data_in_o,
  // two-wire serial on port 3
  input  wire logic                  twi_data_low_i,
  input  wire logic                  twi_clock_low_i,
  input  wire logic                  twi_enable_i,
  output logic                       twi_data_in_o,
  output logic                       twi_clock_in_o,
  // port-4 serial channels
  input  wire pafs_pkg::pafs_ser_out_t [1:0] ser_out_i,
  output pafs_pkg::pafs_ser_in_t       [1:0] ser_in_o,
  // port-5 timer functions
  input  wire logic [1:0]            timer_p2_out0_i,
  output logic                       timer_p2_event_in_o,
  output logic                       timer_p2_capture_in_o,
  output logic      [1:0]            timer_p2_irq_in0_o,
  output logic      [1:0]            ext_irq_p5_o,
  // analog
  output logic      [7:0]            analog_in_ch0_o,
  output logic      [7:0]            analog_in_en_o,
  input  wire logic [1:0]            analog_out_ch0_i,
  output logic      [1:0]            analog_out_pad_o,
  // external bus address
  input  wire logic [12:0]           ext_bus_addr_bit0_i
);

  // control registers, one bit per pad; port-5 ext select and edge selects two bits each
  logic [32:0] port_data;
  logic [32:0] pin_direction_bit;
  logic [32:0] pin_mode_control_bit;
  logic [32:0] function_select_bit;
  logic [1:0]  function_select_ext_bit;
  logic [1:0]  rising_edge_sel_reg_p5;
  logic [1:0]  falling_edge_sel_reg_p5;

  // pad input synchronisers
  logic [32:0] pad_meta;
  logic [32:0] pad_sync;
  logic [32:0] pad_prev;
  logic        trst_meta;
  logic        trst_sync;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_meta  <= 33'h0_0000_0000;
      pad_sync  <= 33'h0_0000_0000;
      pad_prev  <= 33'h0_0000_0000;
      trst_meta <= 1'b0;
      trst_sync <= 1'b0;
    end else begin
      pad_meta  <= pad_in_i;
      pad_sync  <= pad_meta;
      pad_prev  <= pad_sync;
      trst_meta <= debug_reset_i;
      trst_sync <= trst_meta;
    end
  end

  // apb decode; zero wait states, unmapped reads zero and flags error
  wire        wr_en   = psel_i & penable_i & pwrite_i;
  wire        hit_dat = paddr_i == `PAFS_OFF_DATA;
  wire        hit_dir = paddr_i == `PAFS_OFF_DIR;
  wire        hit_mod = paddr_i == `PAFS_OFF_MODE;
  wire        hit_fs  = paddr_i == `PAFS_OFF_FSEL;
  wire        hit_fx  = paddr_i == `PAFS_OFF_FSELX;
  wire        hit_ri  = paddr_i == `PAFS_OFF_RISE;
  wire        hit_fa  = paddr_i == `PAFS_OFF_FALL;
  wire        hit_pin = paddr_i == `PAFS_OFF_PIN;
  wire        hit_ev  = paddr_i == `PAFS_OFF_EVENT;
  wire        hit_any = hit_dat | hit_dir | hit_mod | hit_fs | hit_fx |
                        hit_ri | hit_fa | hit_pin | hit_ev;
  // registers hold the low 32 pads; pad 32 (top address bit) in bit 0
  // of an upper-word alias would waste a map slot, so its bits ride in
  // the same word via wrap: low word covers pads 0..31, pad 32 mirrors 31
  logic [1:0]  ev_flag;
  wire  [31:0] rd_mux =
      hit_dat ? port_data[31:0] :
      hit_dir ? pin_direction_bit[31:0] :
      hit_mod ? pin_mode_control_bit[31:0] :
      hit_fs  ? function_select_bit[31:0] :
      hit_fx  ? {30'h0000_0000, function_select_ext_bit} :
      hit_ri  ? {30'h0000_0000, rising_edge_sel_reg_p5} :
      hit_fa  ? {30'h0000_0000, falling_edge_sel_reg_p5} :
      hit_pin ? pad_sync[31:0] :
      hit_ev  ? {29'h0000_0000, trst_sync, ev_flag} : 32'h0000_0000;

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_any;

  // read data from a flop, loaded in the setup cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i & ~penable_i)
      prdata_o <= rd_mux;
  end

  // writable control; pad 32 shares control with pad 31 in each word
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_data               <= `PAFS_RST_DATA;
      pin_direction_bit       <= `PAFS_RST_DIR;
      pin_mode_control_bit    <= `PAFS_RST_MODE;
      function_select_bit     <= `PAFS_RST_FSEL;
      function_select_ext_bit <= 2'h0;
      rising_edge_sel_reg_p5  <= 2'h0;
      falling_edge_sel_reg_p5 <= 2'h0;
    end else if (wr_en) begin
      if (hit_dat) port_data <= {pwdata_i[31], pwdata_i};
      if (hit_dir) pin_direction_bit <= {pwdata_i[31], pwdata_i};
      if (hit_mod) pin_mode_control_bit <= {pwdata_i[31], pwdata_i};
      if (hit_fs)  function_select_bit <= {pwdata_i[31], pwdata_i};
      if (hit_fx)  function_select_ext_bit <= pwdata_i[1:0];
      if (hit_ri)  rising_edge_sel_reg_p5 <= pwdata_i[1:0];
      if (hit_fa)  falling_edge_sel_reg_p5 <= pwdata_i[1:0];
    end
  end

  // port-5 edge detect; sticky event flags, write 1 clears, set wins
  wire [1:0] p5_now  = pad_sync[`PAFS_P5_LSB +: 2];
  wire [1:0] p5_old  = pad_prev[`PAFS_P5_LSB +: 2];
  wire [1:0] p5_irq_mode = pin_mode_control_bit[`PAFS_P5_LSB +: 2] &
                           ~function_select_ext_bit &
                           ~function_select_bit[`PAFS_P5_LSB +: 2];
  wire [1:0] p5_edge = p5_irq_mode &
                       ((p5_now & ~p5_old & rising_edge_sel_reg_p5) |
                        (~p5_now & p5_old & falling_edge_sel_reg_p5)); // RULE9
  assign ext_irq_p5_o = p5_edge;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      ev_flag <= 2'h0;
    else
      ev_flag <= p5_edge | (ev_flag & ~({2{wr_en & hit_ev}} & pwdata_i[1:0]));
  end

  // per-pad port default: mode 0 gives general port
  logic [32:0] alt_out;
  logic [32:0] alt_oe;
  wire  [32:0] port_oe  = ~pin_direction_bit;
  wire  [32:0] mux_out;
  wire  [32:0] mux_oe;

  genvar g;
  generate
    for (g = 0; g < `PAFS_NPINS; g++) begin : g_pad
      assign mux_out[g] = pin_mode_control_bit[g] ? alt_out[g]
                                                  : port_data[g]; // RULE14
      assign mux_oe[g]  = pin_mode_control_bit[g] ? alt_oe[g]
                                                  : port_oe[g]; // RULE13
    end
  endgenerate

  // port-2 debug override; ignores every register while held high
  wire trst = trst_sync; // RULE1
  assign pad_out_o[1:0] = trst ? {dbg_data_out_i, 1'b0} : mux_out[1:0];
  assign pad_oe_o[1:0]  = trst ? 2'b10 : mux_oe[1:0]; // RULE2
  assign dbg_data_in_o  = trst & pad_sync[0];
  assign pad_out_o[32:2] = mux_out[32:2];
  assign pad_oe_o[32:2]  = mux_oe[32:2];

  // alternate function selection
  wire [5:0] fs4 = function_select_bit[`PAFS_P4_LSB +: 6];
  wire [1:0] fs5 = function_select_bit[`PAFS_P5_LSB +: 2];
  wire [1:0] m5  = pin_mode_control_bit[`PAFS_P5_LSB +: 2];
  always_comb begin
    alt_out = 33'h0_0000_0000;
    alt_oe  = 33'h0_0000_0000;
    // port 2 has no listed function here; keep as inputs
    // port 3: two-wire pins drive low only
    alt_out[`PAFS_P3_LSB]     = 1'b0;
    alt_out[`PAFS_P3_LSB + 1] = 1'b0;
    alt_oe[`PAFS_P3_LSB]      = twi_enable_i & twi_data_low_i; // RULE3
    alt_oe[`PAFS_P3_LSB + 1]  = twi_enable_i & twi_clock_low_i; // RULE3
    // port 4, two channels of out/in/clock
    for (int c = 0; c < 2; c++) begin
      alt_out[`PAFS_P4_LSB + 3*c] = fs4[3*c] ? ser_out_i[c].uart_a_transmit
                                    : ser_out_i[c].csi_a_data_out; // RULE4
      alt_oe[`PAFS_P4_LSB + 3*c]  = 1'b1;
      alt_oe[`PAFS_P4_LSB + 3*c + 1] = 1'b0; // RULE5
      alt_out[`PAFS_P4_LSB + 3*c + 2] = ser_out_i[c].csi_a_serial_clock_out;
      alt_oe[`PAFS_P4_LSB + 3*c + 2]  = ~fs4[3*c + 2] &
                         ser_out_i[c].csi_a_serial_clock_oe; // RULE6
    end
    // port 5: timer output only in ext=0, fs=1
    for (int c = 0; c < 2; c++) begin
      alt_out[`PAFS_P5_LSB + c] = timer_p2_out0_i[c];
      alt_oe[`PAFS_P5_LSB + c]  = ~function_select_ext_bit[c] &
                                  fs5[c]; // RULE7 RULE8
    end
    // port 7 analog: never driven
    // low address port outputs address bits
    for (int a = 0; a < 13; a++) begin
      alt_out[`PAFS_AL_LSB + a] = ext_bus_addr_bit0_i[a];
      alt_oe[`PAFS_AL_LSB + a]  = 1'b1; // RULE12
    end
  end

  // peripheral inputs; gated so an unselected function sees idle low
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ser_in_o[c].csi_a_data_in = pin_mode_control_bit[`PAFS_P4_LSB+3*c+1] &
          ~fs4[3*c+1] & pad_sync[`PAFS_P4_LSB + 3*c + 1]; // RULE5
      ser_in_o[c].uart_a_receive = pin_mode_control_bit[`PAFS_P4_LSB+3*c+1] &
          fs4[3*c+1] & pad_sync[`PAFS_P4_LSB + 3*c + 1]; // RULE5
      ser_in_o[c].csi_a_serial_clock_in =
          pin_mode_control_bit[`PAFS_P4_LSB+3*c+2] & ~fs4[3*c+2] &
          pad_sync[`PAFS_P4_LSB + 3*c + 2]; // RULE6
      ser_in_o[c].uart_a_baud_clock_in =
          pin_mode_control_bit[`PAFS_P4_LSB+3*c+2] & fs4[3*c+2] &
          pad_sync[`PAFS_P4_LSB + 3*c + 2]; // RULE6
    end
  end

  // ext=1, fs=0 on pin 0 fans out to three timer inputs at once
  wire [1:0] p5_tin = m5 & function_select_ext_bit & ~fs5 & p5_now;
  assign timer_p2_event_in_o   = p5_tin[0]; // RULE7
  assign timer_p2_capture_in_o = p5_tin[0]; // RULE7
  assign timer_p2_irq_in0_o    = p5_tin; // RULE8

  // two-wire receive side reads pads back
  assign twi_data_in_o  = pad_sync[`PAFS_P3_LSB];
  assign twi_clock_in_o = pad_sync[`PAFS_P3_LSB + 1];

  // analog paths; port 7 direction register has no effect while the mode bit is set
  assign analog_in_en_o   = pin_mode_control_bit[`PAFS_P7_LSB +: 8]; // RULE10
  assign analog_in_ch0_o  = pad_sync[`PAFS_P7_LSB +: 8] & analog_in_en_o;
  assign analog_out_pad_o = analog_out_ch0_i; // RULE11

endmodule

`default_nettype wire

// ==== core/pafs_pkg.sv ====
package pafs_pkg;

  // function selection of one shared pin
  typedef enum logic [1:0] {
    PAFS_SEL_A,
    PAFS_SEL_B,
    PAFS_SEL_C,
    PAFS_SEL_D
  } pafs_sel_t;

  // one pad: output value and output enable
  typedef struct packed {
    logic dout;
    logic oe;
  } pafs_pad_t;

  // the serial unit bundle for one port-4 channel
  typedef struct packed {
    logic csi_a_data_out;
    logic uart_a_transmit;
    logic csi_a_serial_clock_out;
    logic csi_a_serial_clock_oe;
  } pafs_ser_out_t;

  typedef struct packed {
    logic csi_a_data_in;
    logic uart_a_receive;
    logic csi_a_serial_clock_in;
    logic uart_a_baud_clock_in;
  } pafs_ser_in_t;

endpackage

// ==== test/pafs_mux_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the pin mux
module pafs_mux_asserts (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic [32:0] pad_in_i,
  input wire logic [32:0] pad_out_o,
  input wire logic [32:0] pad_oe_o,
  input wire logic        debug_reset_i,
  input wire logic        dbg_data_out_i,
  input wire logic        dbg_data_in_o,
  input wire logic        twi_data_in_o,
  input wire logic        timer_p2_event_in_o,
  input wire logic        timer_p2_capture_in_o,
  input wire logic [1:0]  timer_p2_irq_in0_o,
  input wire logic [1:0]  ext_irq_p5_o,
  input wire logic [7:0]  analog_in_ch0_o,
  input wire logic [7:0]  analog_in_en_o,
  input wire logic [1:0]  analog_out_ch0_i,
  input wire logic [1:0]  analog_out_pad_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // cycles since reset, so sync history never reaches into reset
  logic [1:0] up;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;

  property p_aout; analog_out_pad_o == analog_out_ch0_i; endproperty
  a_aout: assert property (p_aout) else $error("aout");
  property p_agate; (analog_in_ch0_o & ~analog_in_en_o) == 8'h00; endproperty
  a_agate: assert property (p_agate) else $error("agate");
  property p_ahiz; (pad_oe_o[19:12] & analog_in_en_o) == 8'h00; endproperty
  a_ahiz: assert property (p_ahiz) else $error("ahiz");
  property p_dbg_off; (!debug_reset_i)[*4] |-> !dbg_data_in_o; endproperty
  a_dbg_off: assert property (p_dbg_off) else $error("dbg off");
  property p_dbg_on; debug_reset_i[*4] |-> pad_oe_o[1:0] == 2'h2
    && pad_out_o[1] == dbg_data_out_i; endproperty
  a_dbg_on: assert property (p_dbg_on) else $error("dbg on");
  property p_twi; up == 2'h3 |-> twi_data_in_o == $past(pad_in_i[2], 2);
  endproperty
  a_twi: assert property (p_twi) else $error("twi sync");
  property p_irq; ext_irq_p5_o[0] |=> !ext_irq_p5_o[0]; endproperty
  a_irq: assert property (p_irq) else $error("irq pulse");
  property p_fan; timer_p2_event_in_o == timer_p2_capture_in_o
    && timer_p2_capture_in_o == timer_p2_irq_in0_o[0]; endproperty
  a_fan: assert property (p_fan) else $error("fan");
endmodule
`default_nettype wire

// ==== test/pafs_mux_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pafs_defs.svh"
module pafs_mux_test;
  logic        sys_clk_i, rstn_i, psel_i, penable_i, pwrite_i, e;
  logic        debug_reset_i, dbg_data_out_i, dbg_data_in_o;
  logic        twi_data_low_i, twi_clock_low_i, twi_enable_i;
  logic        pready_o, pslverr_o, twi_data_in_o, twi_clock_in_o;
  logic        timer_p2_event_in_o, timer_p2_capture_in_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [32:0] pad_in_i, pad_out_o, pad_oe_o, ext_en, ext_val;
  logic [12:0] ext_bus_addr_bit0_i;
  logic [7:0]  analog_in_ch0_o, analog_in_en_o;
  logic [1:0]  timer_p2_out0_i, timer_p2_irq_in0_o, ext_irq_p5_o;
  logic [1:0]  analog_out_ch0_i, analog_out_pad_o;
  pafs_pkg::pafs_ser_out_t [1:0] ser_out_i;
  pafs_pkg::pafs_ser_in_t [1:0] ser_in_o;
  int          err_count, n_checks, cyc, c;

  initial sys_clk_i = 1'b0;
  always #12.5 sys_clk_i = ~sys_clk_i;

  pafs_mux dut (
    .sys_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pad_in_i, .pad_out_o,
    .pad_oe_o, .debug_reset_i, .dbg_data_out_i, .dbg_data_in_o,
    .twi_data_low_i, .twi_clock_low_i, .twi_enable_i, .twi_data_in_o,
    .twi_clock_in_o, .ser_out_i, .ser_in_o, .timer_p2_out0_i,
    .timer_p2_event_in_o, .timer_p2_capture_in_o, .timer_p2_irq_in0_o,
    .ext_irq_p5_o, .analog_in_ch0_o, .analog_in_en_o, .analog_out_ch0_i,
    .analog_out_pad_o, .ext_bus_addr_bit0_i
  );
  pafs_pins u_pins (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(pad_in_i));

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds everything until pready is seen, then one
  // idle edge so a write has landed before the caller looks at pads
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask

  task automatic count_irq;
    c = 0;
    repeat (6) begin
      @(posedge sys_clk_i);
      if (ext_irq_p5_o[0] === 1'b1) c++;
    end
  endtask

  task automatic s_reset;
    chk(pad_oe_o, 33'h0);
    apb(1'b0, `PAFS_OFF_DIR, 32'h0);
    chk(q, 32'hFFFF_FFFF);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({e, q}, 33'h1_0000_0000);
  endtask

  // port mode: latch and direction rule, function bits ignored
  task automatic s_port;
    apb(1'b1, `PAFS_OFF_DATA, 32'h0000_0010);
    apb(1'b1, `PAFS_OFF_DIR, 32'hFFFF_FFEE);
    apb(1'b1, `PAFS_OFF_FSEL, 32'hFFFF_FFFF);
    tick(1);
    chk({pad_oe_o[4], pad_out_o[4], pad_oe_o[0]}, 3'h7);
  endtask

  task automatic s_ser;
    ser_out_i <= 8'h07;
    apb(1'b1, `PAFS_OFF_MODE, 32'h0000_0070);
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, `PAFS_OFF_FSEL, {25'h0, {3{f[0]}}, 4'h0});
      tick(3);
      chk({pad_oe_o[6:4], pad_out_o[4]}, {~f[0], 2'h1, f[0]});
      chk(ser_in_o[0], {2{~f[0], f[0]}});
    end
  endtask

  task automatic s_p5;
    timer_p2_out0_i <= 2'h2;
    apb(1'b1, `PAFS_OFF_MODE, 32'h0000_0C70);
    apb(1'b1, `PAFS_OFF_FSEL, 32'h0000_0C00);
    chk({pad_oe_o[11:10], pad_out_o[11:10]}, 4'hE);
    ext_en[11:10] <= 2'h3;
    ext_val[11:10] <= 2'h1;
    apb(1'b1, `PAFS_OFF_FSEL, 32'h0);
    apb(1'b1, `PAFS_OFF_FSELX, 32'h0000_0003);
    tick(3);
    chk({timer_p2_event_in_o, timer_p2_capture_in_o,
         timer_p2_irq_in0_o, pad_oe_o[11:10]}, 6'h34);
    apb(1'b1, `PAFS_OFF_FSELX, 32'h0);
    apb(1'b1, `PAFS_OFF_RISE, 32'h0000_0401);
    apb(1'b1, `PAFS_OFF_FALL, 32'h0);
    apb(1'b1, `PAFS_OFF_EVENT, 32'h0000_0003);
    ext_val[10] <= 1'b0;
    count_irq();
    chk(c, 0);
    ext_val[10] <= 1'b1;
    count_irq();
    chk(c, 1);
    apb(1'b0, `PAFS_OFF_EVENT, 32'h0);
    chk(q[1:0], 2'h1);
  endtask

  // analog and address pins on, latch and direction left as input
  task automatic s_analog;
    ext_bus_addr_bit0_i <= 13'h1A5A;
    analog_out_ch0_i <= 2'h2;
    apb(1'b1, `PAFS_OFF_MODE, 32'hFFFA_5C70);
    tick(3);
    chk({analog_in_en_o, analog_in_ch0_o}, 16'hA5A5);
    chk(pad_oe_o[19:12], 8'h00);
    chk({pad_oe_o[32:20], pad_out_o[32:20]}, 26'h3FF_FA5A);
    chk(analog_out_pad_o, 2'h2);
  endtask

  task automatic s_twi;
    twi_enable_i <= 1'b1;
    twi_data_low_i <= 1'b1;
    apb(1'b1, `PAFS_OFF_MODE, 32'hFFFA_5C7C);
    chk({pad_oe_o[3:2], pad_oe_o[3:2] & pad_out_o[3:2]}, 4'h4);
    twi_data_low_i <= 1'b0;
    twi_clock_low_i <= 1'b1;
    tick(3);
    chk({pad_oe_o[3:2], pad_oe_o[3:2] & pad_out_o[3:2]}, 4'h8);
    chk(twi_data_in_o, 1'b1);
    chk(twi_clock_in_o, 1'b0);
  endtask

  task automatic s_debug;
    debug_reset_i <= 1'b1;
    dbg_data_out_i <= 1'b1;
    tick(6);
    chk({pad_oe_o[1:0], pad_out_o[1], dbg_data_in_o}, 4'hB);
    apb(1'b0, `PAFS_OFF_EVENT, 32'h0);
    chk(q[2], 1'b1);
    debug_reset_i <= 1'b0;
    tick(4);
    chk({pad_oe_o[1:0], dbg_data_in_o}, 3'h2);
  endtask

  // hang guard, far above the hundred or so cycles needed
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    {rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {debug_reset_i, dbg_data_out_i, twi_enable_i} = '0;
    {twi_data_low_i, twi_clock_low_i, timer_p2_out0_i} = '0;
    {ser_out_i, analog_out_ch0_i, ext_bus_addr_bit0_i} = '0;
    ext_en = '0;
    ext_val = '0;
    repeat (5) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    s_reset();
    s_port();
    s_ser();
    s_p5();
    s_analog();
    s_twi();
    s_debug();
    conclude();
  end
endmodule

bind pafs_mux pafs_mux_asserts u_chk (.sys_clk_i, .rstn_i, .pad_in_i,
  .pad_out_o, .pad_oe_o, .debug_reset_i, .dbg_data_out_i, .dbg_data_in_o,
  .twi_data_in_o, .timer_p2_event_in_o, .timer_p2_capture_in_o,
  .timer_p2_irq_in0_o, .ext_irq_p5_o, .analog_in_ch0_o, .analog_in_en_o,
  .analog_out_ch0_i, .analog_out_pad_o);
`default_nettype wire

// ==== test/pafs_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
// board side of the pads: outside drivers plus pull-ups
module pafs_pins (
  input  wire logic [32:0] pad_out_i,
  input  wire logic [32:0] pad_oe_i,
  input  wire logic [32:0] ext_en_i,
  input  wire logic [32:0] ext_val_i,
  output logic      [32:0] pad_in_o
);
  // released pads float high, so open-drain lines read 1
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ~ext_en_i)
                  | (~pad_oe_i & ext_en_i & ext_val_i);
endmodule
`default_nettype wire
